// ===== include/fbl_pkg.sv
// Constants shared by the flash firmware loader and its testbench.
// Assumes a 25 MHz core clock and a serial flash answering the plain read command.
package fbl_pkg;

    // ========================================================================
    // Flash layout
    localparam logic [7:0]  READ_CMD      = 8'h03;
    localparam logic [23:0] LOW_HDR_ADDR  = 24'h000000;
    localparam logic [23:0] HIGH_HDR_ADDR = 24'h001000;
    localparam logic [2:0]  CMD_BYTES     = 3'h4;

    // ========================================================================
    // Header field byte positions (little endian fields)
    localparam int HDR_BYTES    = 12;
    localparam int HDR_MAGIC    = 0;
    localparam int HDR_REGION_POINTER     = 2;
    localparam int HDR_APPLICATION_OFFSET     = 5;
    localparam int HDR_LEN      = 8;
    localparam int HDR_CHECKSUM = 11;
    localparam int CFG_BYTES    = 4;

    // ========================================================================
    // Timing
    localparam int CLK_HZ       = 25_000_000;
    localparam int SPI_HZ       = 12_000_000;
    // Half period rounded up so the flash never sees more than its rated clock
    localparam int SPI_HALF_CYC = (CLK_HZ + 2 * SPI_HZ - 1) / (2 * SPI_HZ);
    localparam int UART_BAUD    = 1_000_000;
    localparam int UART_BIT_CYC = CLK_HZ / UART_BAUD;
    localparam int STRAP_WAIT   = 3;

    // ========================================================================
    // Boot sequencer states
    typedef enum logic [3:0] {
        ST_STRAP     = 4'h0,
        ST_HDR       = 4'h1,
        ST_CHECK     = 4'h2,
        ST_IMG       = 4'h3,
        ST_VERIFY    = 4'h4,
        ST_DONE      = 4'h5,
        ST_INVALID   = 4'h6,
        ST_SECONDARY = 4'h7
    } fbl_state_e;

    typedef logic [23:0] fbl_addr_t;

endpackage

// ===== logic/fbl_fifo2.sv
// Small valid/ready buffer for the image byte stream.
// Assumes one clock domain; flush empties it in one cycle.
module fbl_fifo2 #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ========================================================================
    // Storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // ========================================================================
    // Pointers and fill level
    always_ff @(posedge clock) begin
        if (!rst_n || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    chk_no_overfill : assert property (@(posedge clock) disable iff (!rst_n)
        count_reg <= (PW+1)'(DEPTH)) else $error("buffer count above depth");
endmodule

// ===== logic/fbl_loader.sv
// Boot-time firmware loader: reads headers and image from serial flash over SPI.
// Assumes flash on the SPI pins, strap pin, and a consumer on the image stream.
module fbl_loader #(
    parameter logic [15:0] HEADER_MAGIC = 16'h5a3c, // Arbitrary signature value
    parameter int          FLASH_BYTES  = 1048576
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        strap_pin,
    output logic             spi_sclk,
    output logic             flash_select_n,
    output logic             spi_mosi,
    input  wire logic        spi_miso,
    output logic [7:0]       img_data,
    output logic             img_last,
    output logic             img_valid,
    input  wire logic        img_ready,
    output logic             img_restart,
    output logic [31:0]      default_config,
    output logic             boot_done,
    output logic             boot_high_region,
    output logic             invalid_memory,
    output logic             swd_on_sbu,
    output logic             secondary_mode,
    output logic             uart_tx
);
    localparam int HB = fbl_pkg::HDR_BYTES;

    // ========================================================================
    // Declarations
    fbl_pkg::fbl_state_e state_reg;
    logic [1:0]          strap_sync_reg;
    logic [1:0]          miso_sync_reg;
    logic [1:0]          strap_cnt_reg;
    logic                region_high_reg;
    logic [7:0]          hdr_reg [HB];
    logic [3:0]          hdr_idx_reg;
    logic                go_reg;
    fbl_pkg::fbl_addr_t  go_addr_reg;
    logic [23:0]         go_len_reg;
    logic [7:0]          sum_reg;
    logic [2:0]          cfg_cnt_reg;
    logic [31:0]         cfg_shadow_reg;
    logic                restart_reg;
    logic                busy_reg;
    logic                sclk_reg;
    logic                sel_n_reg;
    logic [3:0]          div_reg;
    logic [2:0]          bit_reg;
    logic [31:0]         tx_sh_reg;
    logic [2:0]          cmd_left_reg;
    logic [23:0]         left_reg;
    logic [7:0]          rx_sh_reg;
    logic [7:0]          rx_byte_reg;
    logic                rx_valid_reg;
    logic                rx_last_reg;
    logic                done_reg;
    logic                may_clock;
    logic                buf_in_ready;
    logic [8:0]          buf_out;
    logic                buf_out_valid;
    logic                uart_busy_reg;
    logic [9:0]          uart_sh_reg;
    logic [3:0]          uart_bits_reg;
    logic [7:0]          uart_div_reg;
    logic                img_fire;
    logic [23:0]         region_pointer;
    logic [23:0]         application_offset;
    logic [23:0]         img_len;
    logic [25:0]         fetch_end;
    logic                hdr_ok;
    logic                fail;

    function automatic logic [23:0] le24(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2);
        le24 = {b2, b1, b0};
    endfunction

    // ========================================================================
    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strap_sync_reg <= 2'h3;
            miso_sync_reg  <= 2'h0;
        end else begin
            strap_sync_reg <= {strap_sync_reg[0], strap_pin};
            miso_sync_reg  <= {miso_sync_reg[0], spi_miso};
        end
    end

    // ========================================================================
    // Header decode
    assign region_pointer      = le24(hdr_reg[fbl_pkg::HDR_REGION_POINTER], hdr_reg[fbl_pkg::HDR_REGION_POINTER+1],
                            hdr_reg[fbl_pkg::HDR_REGION_POINTER+2]);
    assign application_offset      = le24(hdr_reg[fbl_pkg::HDR_APPLICATION_OFFSET], hdr_reg[fbl_pkg::HDR_APPLICATION_OFFSET+1],
                            hdr_reg[fbl_pkg::HDR_APPLICATION_OFFSET+2]);
    assign img_len   = le24(hdr_reg[fbl_pkg::HDR_LEN], hdr_reg[fbl_pkg::HDR_LEN+1],
                            hdr_reg[fbl_pkg::HDR_LEN+2]);
    assign fetch_end = {2'h0, region_pointer} + {2'h0, application_offset} + {2'h0, img_len};
    assign hdr_ok    = ({hdr_reg[fbl_pkg::HDR_MAGIC+1], hdr_reg[fbl_pkg::HDR_MAGIC]} == HEADER_MAGIC)
                       && (img_len != 24'h0) && (fetch_end <= 26'(FLASH_BYTES));
    assign fail      = (state_reg == fbl_pkg::ST_CHECK && !hdr_ok)
                       || (state_reg == fbl_pkg::ST_VERIFY && sum_reg != hdr_reg[fbl_pkg::HDR_CHECKSUM]);

    // ========================================================================
    // Boot sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg       <= fbl_pkg::ST_STRAP;
            strap_cnt_reg   <= 2'h0;
            region_high_reg <= 1'b0;
            hdr_idx_reg     <= 4'h0;
            go_reg          <= 1'b0;
            go_addr_reg     <= 24'h0;
            go_len_reg      <= 24'h0;
            sum_reg         <= 8'h0;
            cfg_cnt_reg     <= 3'h0;
            cfg_shadow_reg  <= 32'h0;
            default_config  <= 32'h0;
            restart_reg     <= 1'b0;
        end else begin
            go_reg      <= 1'b0;
            restart_reg <= 1'b0;
            case (state_reg)
                fbl_pkg::ST_STRAP: begin
                    strap_cnt_reg <= strap_cnt_reg + 1'b1;
                    if (strap_cnt_reg == 2'(fbl_pkg::STRAP_WAIT)) begin
                        if (!strap_sync_reg[1]) begin
                            state_reg   <= fbl_pkg::ST_HDR;
                            go_reg      <= 1'b1;
                            go_addr_reg <= fbl_pkg::LOW_HDR_ADDR;
                            go_len_reg  <= 24'(HB);
                            hdr_idx_reg <= 4'h0;
                        end else begin
                            state_reg <= fbl_pkg::ST_SECONDARY;
                        end
                    end
                end
                fbl_pkg::ST_HDR: begin
                    if (rx_valid_reg) begin
                        hdr_reg[hdr_idx_reg] <= rx_byte_reg;
                        hdr_idx_reg          <= hdr_idx_reg + 1'b1;
                    end
                    if (done_reg) begin
                        state_reg <= fbl_pkg::ST_CHECK;
                    end
                end
                fbl_pkg::ST_CHECK: begin
                    if (hdr_ok) begin
                        state_reg   <= fbl_pkg::ST_IMG;
                        go_reg      <= 1'b1;
                        go_addr_reg <= region_pointer + application_offset;
                        go_len_reg  <= img_len;
                        sum_reg     <= 8'h0;
                        cfg_cnt_reg <= 3'h0;
                    end
                end
                fbl_pkg::ST_IMG: begin
                    if (rx_valid_reg) begin
                        sum_reg <= sum_reg + rx_byte_reg;
                        if (cfg_cnt_reg != 3'(fbl_pkg::CFG_BYTES)) begin
                            cfg_shadow_reg <= {rx_byte_reg, cfg_shadow_reg[31:8]};
                            cfg_cnt_reg    <= cfg_cnt_reg + 1'b1;
                        end
                    end
                    if (done_reg) begin
                        state_reg <= fbl_pkg::ST_VERIFY;
                    end
                end
                fbl_pkg::ST_VERIFY: begin
                    if (!fail) begin
                        state_reg      <= fbl_pkg::ST_DONE;
                        default_config <= cfg_shadow_reg;
                    end
                end
                fbl_pkg::ST_DONE, fbl_pkg::ST_INVALID, fbl_pkg::ST_SECONDARY: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= fbl_pkg::ST_INVALID;
                end
            endcase
            // A half-written low region fails its check and the high region takes over; a failing high region ends in invalid
            if (fail) begin
                if (!region_high_reg) begin
                    region_high_reg <= 1'b1;
                    restart_reg     <= (state_reg == fbl_pkg::ST_VERIFY);
                    state_reg       <= fbl_pkg::ST_HDR;
                    go_reg          <= 1'b1;
                    go_addr_reg     <= fbl_pkg::HIGH_HDR_ADDR;
                    go_len_reg      <= 24'(HB);
                    hdr_idx_reg     <= 4'h0;
                end else begin
                    state_reg <= fbl_pkg::ST_INVALID;
                end
            end
        end
    end

    // ========================================================================
    // SPI master, mode 0
    // Miso is read two cycles late through the synchroniser, so it is taken at the
    // falling edge, which reflects the pin near the rising edge
    assign may_clock = !(state_reg == fbl_pkg::ST_IMG && cmd_left_reg == 3'h0
                         && bit_reg == 3'h0 && !buf_in_ready);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_reg     <= 1'b0;
            sclk_reg     <= 1'b0;
            sel_n_reg    <= 1'b1;
            div_reg      <= 4'h0;
            bit_reg      <= 3'h0;
            tx_sh_reg    <= 32'h0;
            cmd_left_reg <= 3'h0;
            left_reg     <= 24'h0;
            rx_sh_reg    <= 8'h0;
            rx_byte_reg  <= 8'h0;
            rx_valid_reg <= 1'b0;
            rx_last_reg  <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            done_reg     <= 1'b0;
            if (go_reg) begin
                busy_reg     <= 1'b1;
                sel_n_reg    <= 1'b0;
                sclk_reg     <= 1'b0;
                div_reg      <= 4'h0;
                bit_reg      <= 3'h0;
                tx_sh_reg    <= {fbl_pkg::READ_CMD, go_addr_reg};
                cmd_left_reg <= fbl_pkg::CMD_BYTES;
                left_reg     <= go_len_reg;
            end else if (busy_reg) begin
                if (div_reg == 4'(fbl_pkg::SPI_HALF_CYC - 1)) begin
                    div_reg <= 4'h0;
                    if (!sclk_reg) begin
                        sclk_reg <= may_clock;
                    end else begin
                        sclk_reg  <= 1'b0;
                        rx_sh_reg <= {rx_sh_reg[6:0], miso_sync_reg[1]};
                        tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
                        bit_reg   <= bit_reg + 1'b1;
                        if (bit_reg == 3'h7) begin
                            if (cmd_left_reg != 3'h0) begin
                                cmd_left_reg <= cmd_left_reg - 1'b1;
                            end else begin
                                rx_byte_reg  <= {rx_sh_reg[6:0], miso_sync_reg[1]};
                                rx_valid_reg <= 1'b1;
                                rx_last_reg  <= (left_reg == 24'h1);
                                left_reg     <= left_reg - 1'b1;
                                if (left_reg == 24'h1) begin
                                    busy_reg  <= 1'b0;
                                    sel_n_reg <= 1'b1;
                                    done_reg  <= 1'b1;
                                end
                            end
                        end
                    end
                end else begin
                    div_reg <= div_reg + 1'b1;
                end
            end
        end
    end

    assign spi_sclk       = sclk_reg;
    assign flash_select_n = sel_n_reg;
    assign spi_mosi       = tx_sh_reg[31];

    // ========================================================================
    // Image stream buffer; a stall here holds the serial clock between bytes
    fbl_fifo2 #(
        .WIDTH (9),
        .DEPTH (2)
    ) u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .flush     (restart_reg),
        .in_data   ({rx_last_reg, rx_byte_reg}),
        .in_valid  (rx_valid_reg && state_reg == fbl_pkg::ST_IMG),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (img_ready && !uart_busy_reg)
    );

    assign img_data  = buf_out[7:0];
    assign img_last  = buf_out[8];
    assign img_valid = buf_out_valid && !uart_busy_reg;
    assign img_fire  = img_valid && img_ready;

    // ========================================================================
    // UART forwarding to the secondary, 8N1
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            uart_busy_reg <= 1'b0;
            uart_sh_reg   <= 10'h3ff;
            uart_bits_reg <= 4'h0;
            uart_div_reg  <= 8'h0;
        end else if (img_fire) begin
            uart_busy_reg <= 1'b1;
            uart_sh_reg   <= {1'b1, buf_out[7:0], 1'b0};
            uart_bits_reg <= 4'h0;
            uart_div_reg  <= 8'h0;
        end else if (uart_busy_reg) begin
            if (uart_div_reg == 8'(fbl_pkg::UART_BIT_CYC - 1)) begin
                uart_div_reg  <= 8'h0;
                uart_sh_reg   <= {1'b1, uart_sh_reg[9:1]};
                uart_bits_reg <= uart_bits_reg + 1'b1;
                uart_busy_reg <= (uart_bits_reg != 4'h9);
            end else begin
                uart_div_reg <= uart_div_reg + 1'b1;
            end
        end
    end

    assign uart_tx          = uart_sh_reg[0];
    assign img_restart      = restart_reg;
    assign boot_done        = (state_reg == fbl_pkg::ST_DONE);
    assign boot_high_region = region_high_reg;
    assign invalid_memory   = (state_reg == fbl_pkg::ST_INVALID);
    assign swd_on_sbu       = invalid_memory;
    assign secondary_mode   = (state_reg == fbl_pkg::ST_SECONDARY);

    // ========================================================================
    // Checks
    chk_sclk_idle_low : assert property (@(posedge clock) disable iff (!rst_n)
        !busy_reg |-> !spi_sclk) else $error("serial clock not low while idle");
    chk_select_covers_clk : assert property (@(posedge clock) disable iff (!rst_n)
        spi_sclk |-> !flash_select_n) else $error("clock pulse outside select");
    chk_first_bit : assert property (@(posedge clock) disable iff (!rst_n)
        $fell(flash_select_n) |-> spi_mosi == fbl_pkg::READ_CMD[7] && tx_sh_reg[31:24] == fbl_pkg::READ_CMD)
        else $error("first bit not ready");
    chk_mosi_high_stable : assert property (@(posedge clock) disable iff (!rst_n)
        spi_sclk && $past(spi_sclk) |-> $stable(spi_mosi)) else $error("mosi moved while clock high");
    chk_low_first : assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_reg) == fbl_pkg::ST_STRAP && state_reg == fbl_pkg::ST_HDR
        |-> !region_high_reg && go_addr_reg == fbl_pkg::LOW_HDR_ADDR) else $error("low region not first");
    chk_fallback : assert property (@(posedge clock) disable iff (!rst_n)
        fail && !region_high_reg |=> region_high_reg && go_reg && go_addr_reg == fbl_pkg::HIGH_HDR_ADDR)
        else $error("no fallback to high region");
    chk_invalid_flow : assert property (@(posedge clock) disable iff (!rst_n)
        fail && region_high_reg |=> invalid_memory && swd_on_sbu) else $error("invalid flow not entered");
    chk_fetch_addr : assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == fbl_pkg::ST_CHECK && hdr_ok |=> go_addr_reg == $past(region_pointer) + $past(application_offset))
        else $error("fetch address wrong");
    chk_secondary_quiet : assert property (@(posedge clock) disable iff (!rst_n)
        secondary_mode |-> flash_select_n && !busy_reg) else $error("secondary touched flash");
    chk_config_load : assert property (@(posedge clock) disable iff (!rst_n)
        $rose(boot_done) |-> default_config == cfg_shadow_reg) else $error("config not taken from image");
endmodule

// ===== verification/fbl_flash_model.sv
// Behavioural serial flash on the loader's SPI pins.
// Assumes mode 0 and the plain read command with a 24-bit address.
module fbl_flash_model (
    input  wire logic sclk,
    input  wire logic sel_n,
    input  wire logic mosi,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Storage and shift state
    logic [7:0]  mem [int];
    logic [31:0] cmd;
    logic [7:0]  b;
    logic        last = 0;
    int          nbit = 0;
    initial miso = 1;
    always @(negedge sel_n) nbit = 0;
    always @(posedge sclk) if (!sel_n) begin
        if (nbit < 32) cmd = {cmd[30:0], mosi};
        nbit = nbit + 1;
    end
    always @(negedge sclk or posedge sel_n) begin
        if (sel_n) miso <= ~last; // Released line must not hold a stale bit
        else if (nbit >= 32) begin
            b = mem.exists((cmd[23:0] + (nbit - 32) / 8) % 1048576) ? mem[(cmd[23:0] + (nbit - 32) / 8) % 1048576] : 8'hff;
            last = b[7 - (nbit - 32) % 8];
            miso <= last;
        end
    end
endmodule

// ===== verification/tb_top.sv
// Boots from low, from high, from high after a cut-short low, with both headers bad, then strapped to secondary.
// Assumes the flash model answers on the SPI pins.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Signals and counters
    localparam logic [15:0] MAGIC = 16'h1234; // Arbitrary value
    logic clock = 0, rst_n = 0, img_ready = 0, strap = 0, sclk, sel_n, mosi, miso, last, valid, rst_img;
    logic done, high, inval, swd, sec, utx;
    logic [7:0]  data;
    logic [31:0] cfg_o;
    logic [9:0]  exp_q [$];
    logic [9:0]  e;
    logic [7:0]  u_q [$];
    logic [7:0]  u_byte;
    int errors = 0, n_compared = 0, seed = 1, cyc = 0, n_rst = 0;
    always #20 clock = ~clock;
    fbl_flash_model fbl_flash_model_i (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso));
    fbl_loader #(.HEADER_MAGIC(MAGIC)) fbl_loader_i (.clock(clock), .rst_n(rst_n), .strap_pin(strap),
        .spi_sclk(sclk), .flash_select_n(sel_n), .spi_mosi(mosi), .spi_miso(miso), .img_data(data),
        .img_last(last), .img_valid(valid), .img_ready(img_ready), .img_restart(rst_img),
        .default_config(cfg_o), .boot_done(done), .boot_high_region(high), .invalid_memory(inval),
        .swd_on_sbu(swd), .secondary_mode(sec), .uart_tx(utx));
    // ========================================
    // Compare and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ========================================
    // Output watcher; random stalls on the stream
    always @(posedge clock) begin
        cyc <= cyc + 1;
        img_ready <= 1'($random(seed));
        if (cyc > 60000) begin
            errors++;
            summarize();
        end
        if (valid && img_ready) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            u_q.push_back(e[7:0]);
            check({last, data}, e[8:0]);
        end
        // Flushed low-region bytes never reach the port, so their notes go
        if (rst_img) begin
            n_rst++;
            while (exp_q.size() > 0 && !exp_q[0][9]) exp_q.delete(0);
        end
        if (sel_n) check(sclk, 0);
    end
    always @(negedge sel_n) #1 check(mosi, fbl_pkg::READ_CMD[7]);
    always @(posedge sel_n) if (rst_n) check(fbl_flash_model_i.cmd[31:24], fbl_pkg::READ_CMD);
    // ========================================
    // Listener on the forwarded stream, 8N1
    initial forever begin
        @(negedge utx);
        repeat (fbl_pkg::UART_BIT_CYC + fbl_pkg::UART_BIT_CYC / 2) @(posedge clock);
        for (int k = 0; k < 8; k++) begin
            u_byte[k] = utx;
            if (k < 7) repeat (fbl_pkg::UART_BIT_CYC) @(posedge clock);
        end
        repeat (fbl_pkg::UART_BIT_CYC) @(posedge clock);
        check({utx, u_byte}, {1'b1, u_q.size() ? u_q.pop_front() : 8'hxx});
    end
    // ========================================
    // Header and image builder
    task automatic hdr(input int base, input logic [15:0] mg, input int ptr, input int len, input logic use_it,
                       input logic bad, inout logic [31:0] cfg);
        logic [7:0]  s = 0;
        logic [95:0] h;
        for (int i = 0; i < len; i++) begin
            fbl_flash_model_i.mem[ptr + 16 + i] = 8'($random(seed));
            s += fbl_flash_model_i.mem[ptr + 16 + i];
            if (use_it) exp_q.push_back({base != 0, i == len - 1, fbl_flash_model_i.mem[ptr + 16 + i]});
            if (use_it && !bad && i < 4) cfg[8*i+:8] = fbl_flash_model_i.mem[ptr + 16 + i];
        end
        // A wrong checksum stands for an update cut short
        h = {s ^ {7'h0, bad}, 24'(len), 24'h000010, 24'(ptr), mg};
        for (int j = 0; j < 12; j++) fbl_flash_model_i.mem[base + j] = h[8*j+:8];
    endtask
    task automatic run(input logic st, input logic lo, input logic bad, input logic hi);
        logic [31:0] cfg = 0;
        logic        ok = lo & !bad;
        fbl_flash_model_i.mem.delete();
        hdr(0, lo ? MAGIC : 16'h0000, 'h2000, 6, lo & !st, bad, cfg);
        hdr(fbl_pkg::HIGH_HDR_ADDR, hi ? MAGIC : 16'h0000, 'h3000, 5, hi & !ok & !st, 1'b0, cfg);
        rst_n <= 0;
        strap <= st;
        n_rst = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1;
        for (int i = 0; i < 20000 && (exp_q.size() > 0 || !(done || inval || sec)); i++) @(posedge clock);
        // Let the last forwarded byte leave before the next reset cuts it
        repeat (300) @(posedge clock);
        check(exp_q.size() + u_q.size(), 0);
        check({done, high, inval, swd, sec},
              {!st & (ok | hi), !st & !ok, !st & !(ok | hi), !st & !(ok | hi), st});
        check(n_rst, !st & lo & bad);
        if (!st & (ok | hi)) check(cfg_o, cfg);
    endtask
    initial begin
        run(0, 1, 0, 1);
        run(0, 0, 0, 1);
        run(0, 1, 1, 1);
        run(0, 0, 0, 0);
        run(1, 1, 0, 1);
        summarize();
    end
endmodule
